// file: hw/osc_multiplier_control_defs.svh
// constants for the oscillator trim and clock multiplier block
// assumes an 8-bit special-function register port clocked at 10 MHz
`ifndef OSC_MULTIPLIER_CONTROL_DEFS_SVH
`define OSC_MULTIPLIER_CONTROL_DEFS_SVH

// register addresses
`define FINE_TRIM_ADDR      8'h9E
`define COARSE_TRIM_ADDR    8'hA2
`define MULT_CTRL_ADDR      8'h97
// multiplier control field positions
`define MULT_EN_BIT         7
`define MULT_INIT_BIT       6
`define MULT_RDY_BIT        5
`define MULT_SCALE_HI       4
`define MULT_SCALE_LO       2
`define MULT_INSEL_HI       1
`define MULT_INSEL_LO       0
// reset values; trim values stand in for the factory calibration
`define COARSE_TRIM_RST     7'h40
`define FINE_TRIM_RST       6'h20
`define MULT_CTRL_RST       8'h00
// input select and system clock source codes
`define INSEL_INT_HALF      2'h0
`define INSEL_EXT_HALF      2'h1
`define INSEL_EXT_FULL      2'h2
`define SYSTEM_CLOCK_SRC_MULT     2'h2
// timing
`define CLK_PERIOD_NS       100
`define MULT_LOCK_NS        1000
`define MULT_LOCK_CYC       ((`MULT_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// half periods in one slow-input burst (four pulses)
`define BURST_HALVES        4'h8

`endif

// file: hw/osc_multiplier_control_pkg.sv
// types shared by the oscillator trim and clock multiplier block
// assumes osc_multiplier_control_defs.svh for all numeric constants
package osc_multiplier_control_pkg;

  // software-visible multiplier settings
  typedef struct packed {
    logic       enable;
    logic       initialize;
    logic [2:0] scale;
    logic [1:0] insel;
  } mult_ctrl_s;

  // multiplier lifecycle, one-hot
  typedef enum logic [3:0] {
    ST_OFF     = 4'h1,
    ST_ENABLED = 4'h2,
    ST_LOCKING = 4'h4,
    ST_READY   = 4'h8
  } mult_state_e;

endpackage

// file: hw/osc_multiplier_control.sv
// oscillator trim registers and clock multiplier control with slow-input pulse model
// assumes a synchronous register port and oscillator levels sampled on sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "osc_multiplier_control_defs.svh"

module osc_multiplier_control
  import osc_multiplier_control_pkg::*;
(
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // oscillator levels and system clock select
  input  wire logic       int_osc_level,
  input  wire logic       ext_osc_level,
  input  wire logic [1:0] system_clock_source_select,
  // trim and multiplier outputs
  output logic      [6:0] coarse_trim,
  output logic      [5:0] fine_trim,
  output mult_ctrl_s      mult_cfg,
  output logic            mult_ready,
  output logic      [2:0] mult_base_factor,
  output logic            mult_clk_out,
  output logic            system_clock_from_mult
);

  localparam logic [3:0] LOCK_CYC = 4'(`MULT_LOCK_CYC);

  // =====================================================================
  // register writes
  // =====================================================================
  logic       wr_coarse;
  logic       wr_fine;
  logic       wr_ctrl;
  logic [6:0] next_coarse;
  logic [5:0] next_fine;
  mult_ctrl_s next_cfg;
  logic [7:0] next_rdata;

  assign wr_coarse = ce && sfr_wr && (sfr_addr == `COARSE_TRIM_ADDR);
  assign wr_fine   = ce && sfr_wr && (sfr_addr == `FINE_TRIM_ADDR);
  assign wr_ctrl   = ce && sfr_wr && (sfr_addr == `MULT_CTRL_ADDR);

  // next register contents; bit 7 of coarse and bits 7:6 of fine are dropped
  always_comb begin
    next_coarse = coarse_trim;
    next_fine   = fine_trim;
    next_cfg    = mult_cfg;
    if (wr_coarse) begin
      next_coarse = sfr_wdata[6:0];
    end
    if (wr_fine) begin
      next_fine = sfr_wdata[5:0];
    end
    // ready bit is not stored, so writes to it have no effect
    if (wr_ctrl) begin
      next_cfg.enable     = sfr_wdata[`MULT_EN_BIT];
      next_cfg.initialize = sfr_wdata[`MULT_INIT_BIT];
      next_cfg.scale      = sfr_wdata[`MULT_SCALE_HI:`MULT_SCALE_LO];
      next_cfg.insel      = sfr_wdata[`MULT_INSEL_HI:`MULT_INSEL_LO];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = sfr_rdata;
    if (ce && sfr_rd) begin
      case (sfr_addr)
        `COARSE_TRIM_ADDR: next_rdata = {1'b0, coarse_trim};
        `FINE_TRIM_ADDR:   next_rdata = {2'b00, fine_trim};
        `MULT_CTRL_ADDR:   next_rdata = {mult_cfg.enable, mult_cfg.initialize, mult_ready,
                                         mult_cfg.scale, mult_cfg.insel};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  // new trim takes effect next cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_trim <= `COARSE_TRIM_RST;
      fine_trim   <= `FINE_TRIM_RST;
      mult_cfg    <= mult_ctrl_s'(7'(`MULT_CTRL_RST));
      sfr_rdata   <= 8'h00;
    end else if (ce) begin
      coarse_trim <= next_coarse;
      fine_trim   <= next_fine;
      mult_cfg    <= next_cfg;
      sfr_rdata   <= next_rdata;
    end
  end

  // =====================================================================
  // multiplier lifecycle
  // =====================================================================
  mult_state_e state;
  mult_state_e next_state;
  logic [3:0]  lock_cnt;
  logic [3:0]  next_lock_cnt;

  // lock time is a fixed model; the real loop settles on its own schedule
  always_comb begin
    next_state    = state;
    next_lock_cnt = lock_cnt;
    case (state)
      ST_OFF: begin
        if (next_cfg.enable) begin
          next_state = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (!next_cfg.enable) begin
          next_state = ST_OFF;
        end else if (wr_ctrl && sfr_wdata[`MULT_INIT_BIT]) begin
          next_state    = ST_LOCKING;
          next_lock_cnt = LOCK_CYC;
        end
      end
      ST_LOCKING: begin
        if (!next_cfg.enable) begin
          next_state = ST_OFF;
        end else if (lock_cnt <= 4'h1) begin
          next_state    = ST_READY;
          next_lock_cnt = 4'h0;
        end else begin
          next_lock_cnt = lock_cnt - 4'h1;
        end
      end
      ST_READY: begin
        if (!next_cfg.enable) begin
          next_state = ST_OFF;
        end else if (wr_ctrl && sfr_wdata[`MULT_INIT_BIT]) begin
          next_state    = ST_LOCKING;
          next_lock_cnt = LOCK_CYC;
        end
      end
      default: begin
        next_state    = ST_OFF;
        next_lock_cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_OFF;
      lock_cnt <= 4'h0;
    end else if (ce) begin
      state    <= next_state;
      lock_cnt <= next_lock_cnt;
    end
  end

  // ready only in the settled state
  assign mult_ready = (state == ST_READY);

  // =====================================================================
  // input selection and slow-input pulse bursts
  // =====================================================================
  logic       int_prev;
  logic       ext_prev;
  logic       int_half;
  logic       ext_half;
  logic [3:0] burst_left;
  logic [2:0] next_base;
  logic       next_sys_mult;
  logic       next_int_half;
  logic       next_ext_half;
  logic [3:0] next_burst;
  logic       in_edge;
  logic       int_rise;
  logic       ext_rise;

  assign int_rise = int_osc_level && !int_prev;
  assign ext_rise = ext_osc_level && !ext_prev;

  // halved inputs take every second rising edge
  always_comb begin
    next_int_half = int_rise ? !int_half : int_half;
    next_ext_half = ext_rise ? !ext_half : ext_half;
    case (mult_cfg.insel)
      `INSEL_INT_HALF: in_edge = int_rise && int_half;
      `INSEL_EXT_HALF: in_edge = ext_rise && ext_half;
      `INSEL_EXT_FULL: in_edge = ext_rise;
      default:         in_edge = 1'b0;
    endcase
  end

  // four pulses then idle until next edge
  // base factor two for halved inputs, four for full
  always_comb begin
    next_burst = burst_left;
    if (!mult_ready) begin
      next_burst = 4'h0;
    end else if (in_edge && burst_left == 4'h0) begin
      next_burst = `BURST_HALVES;
    end else if (burst_left != 4'h0) begin
      next_burst = burst_left - 4'h1;
    end
    next_base     = (mult_cfg.insel == `INSEL_EXT_FULL) ? 3'h4 : 3'h2;
    next_sys_mult = (system_clock_source_select == `SYSTEM_CLOCK_SRC_MULT);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_prev         <= 1'b0;
      ext_prev         <= 1'b0;
      int_half         <= 1'b0;
      ext_half         <= 1'b0;
      burst_left       <= 4'h0;
      mult_clk_out     <= 1'b0;
      mult_base_factor <= 3'h2;
      system_clock_from_mult <= 1'b0;
    end else if (ce) begin
      int_prev         <= int_osc_level;
      ext_prev         <= ext_osc_level;
      int_half         <= next_int_half;
      ext_half         <= next_ext_half;
      burst_left       <= next_burst;
      mult_clk_out     <= next_burst[0];
      mult_base_factor <= next_base;
      system_clock_from_mult <= next_sys_mult;
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_coarse_top_zero: assert property (
    (ce && sfr_rd && sfr_addr == `COARSE_TRIM_ADDR) |=> !sfr_rdata[7])
    else $error("coarse trim bit 7 read nonzero");
  chk_fine_top_zero: assert property (
    (ce && sfr_rd && sfr_addr == `FINE_TRIM_ADDR) |=> sfr_rdata[7:6] == 2'b00)
    else $error("fine trim top bits read nonzero");
  chk_coarse_applied: assert property (
    wr_coarse |=> coarse_trim == $past(sfr_wdata[6:0]))
    else $error("coarse trim not applied next cycle");
  chk_fine_applied: assert property (
    wr_fine |=> fine_trim == $past(sfr_wdata[5:0]))
    else $error("fine trim not applied next cycle");
  chk_ready_off: assert property (
    (wr_ctrl && !sfr_wdata[`MULT_EN_BIT]) |=> !mult_ready)
    else $error("ready high after disable");
  chk_lock_done: assert property (
    (ce && state == ST_LOCKING && lock_cnt == 4'h1 && next_cfg.enable) |=> mult_ready)
    else $error("ready did not follow lock");
  chk_ready_cause: assert property (
    $rose(mult_ready) |-> $past(state) == ST_LOCKING)
    else $error("ready rose without locking");
  chk_system_clock_sel: assert property (
    (ce && system_clock_source_select == 2'b10) |=> system_clock_from_mult)
    else $error("multiplier not selected for code 10");
  chk_pulse_in_burst: assert property (
    $rose(mult_clk_out) |-> burst_left != 4'h0 && $past(mult_ready))
    else $error("pulse outside a burst");
  chk_base_four: assert property (
    (ce && mult_cfg.insel == `INSEL_EXT_FULL) |=> mult_base_factor == 3'h4)
    else $error("external full input not times four");

  cov_lock: cover property (state == ST_LOCKING ##[1:20] mult_ready);
  cov_burst: cover property (in_edge && mult_ready ##1 burst_left == `BURST_HALVES);
  cov_relock: cover property (mult_ready ##1 state == ST_LOCKING);

endmodule // osc_multiplier_control
`default_nettype wire

// file: tb/osc_multiplier_control_test.sv
// self-checking bench for the oscillator trim and clock multiplier block
// assumes osc_multiplier_control_defs.svh on the include path and the package compiled first
`timescale 1ns/100ps
`default_nettype none
`include "osc_multiplier_control_defs.svh"

module osc_multiplier_control_test
  import osc_multiplier_control_pkg::*;
;
  // ==========================================================================
  // stimulus and observed signals
  logic       sys_clk, rst_n, ce, sfr_wr, sfr_rd;
  logic       int_osc_level, ext_osc_level, mult_ready, mult_clk_out, system_clock_from_mult;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [1:0] system_clock_source_select;
  logic [6:0] coarse_trim;
  logic [5:0] fine_trim;
  logic [2:0] mult_base_factor;
  mult_ctrl_s mult_cfg;
  int         n_errors, n_compared, cycles, k, highs, pulses;
  logic [7:0] cfg;

  osc_multiplier_control dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .int_osc_level(int_osc_level), .ext_osc_level(ext_osc_level),
    .system_clock_source_select(system_clock_source_select), .coarse_trim(coarse_trim),
    .fine_trim(fine_trim), .mult_cfg(mult_cfg), .mult_ready(mult_ready),
    .mult_base_factor(mult_base_factor), .mult_clk_out(mult_clk_out),
    .system_clock_from_mult(system_clock_from_mult)
  );

  // ==========================================================================
  // clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  // ==========================================================================
  // tasks
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // write strobe is sampled at the second edge; outputs settle just after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    check(what, sfr_rdata, exp);
  endtask

  task automatic count_pulses(input int n);
    highs = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      highs = highs + int'(mult_clk_out === 1'b1);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {rst_n, sfr_wr, sfr_rd, int_osc_level, ext_osc_level} <= 5'h00;
    {sfr_addr, sfr_wdata, system_clock_source_select} <= 18'h00000;
    ce <= 1'b1;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check("coarse_trim", {1'b0, coarse_trim}, {1'b0, `COARSE_TRIM_RST});
    check("fine_trim", {2'h0, fine_trim}, {2'h0, `FINE_TRIM_RST});
    check("mult_ready", {7'h00, mult_ready}, 8'h00);
    rd("coarse read", `COARSE_TRIM_ADDR, {1'b0, `COARSE_TRIM_RST});
    rd("fine read", `FINE_TRIM_ADDR, {2'h0, `FINE_TRIM_RST});
    rd("control read", `MULT_CTRL_ADDR, `MULT_CTRL_RST);
    // boundary trims, top bits must drop and take effect at once
    for (k = 0; k < 8; k++) begin
      wr(`COARSE_TRIM_ADDR, 8'h80 ^ (8'h01 << k));
      check("coarse_trim", {1'b0, coarse_trim}, 8'h01 << k & 8'h7F);
      rd("coarse read", `COARSE_TRIM_ADDR, 8'h01 << k & 8'h7F);
    end
    wr(`COARSE_TRIM_ADDR, 8'hFF);
    check("coarse fastest", {1'b0, coarse_trim}, 8'h7F);
    wr(`COARSE_TRIM_ADDR, 8'h80);
    check("coarse slowest", {1'b0, coarse_trim}, 8'h00);
    wr(`FINE_TRIM_ADDR, 8'hFF);
    rd("fine read", `FINE_TRIM_ADDR, 8'h3F);
    wr(`FINE_TRIM_ADDR, 8'hC5);
    check("fine_trim", {2'h0, fine_trim}, 8'h05);
    // unmapped place and frozen clock enable both leave state alone
    wr(8'h55, 8'h3C);
    rd("unmapped read", 8'h55, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(`COARSE_TRIM_ADDR, 8'h11);
    ce <= 1'b1;
    check("coarse frozen", {1'b0, coarse_trim}, 8'h00);
    // scale codes 0 to 6 and input selects 0 to 2, from a cleared control register
    for (k = 0; k < 7; k++) begin
      wr(`MULT_CTRL_ADDR, 8'h00);
      cfg = 8'((k << 2) | (k % 3));
      wr(`MULT_CTRL_ADDR, cfg);
      check("scale", {5'h00, mult_cfg.scale}, 8'(k));
      // base factor is registered from the stored field, one cycle behind
      @(posedge sys_clk);
      #1;
      check("base", {5'h00, mult_base_factor}, (k % 3 == 2) ? 8'h04 : 8'h02);
    end
    // enable with a ready-bit write that must not stick, then lock
    wr(`MULT_CTRL_ADDR, 8'h00);
    wr(`MULT_CTRL_ADDR, 8'h02);
    wr(`MULT_CTRL_ADDR, 8'hA2);
    check("ready early", {7'h00, mult_ready}, 8'h00);
    repeat (50) @(posedge sys_clk);
    // external level held steady before init
    wr(`MULT_CTRL_ADDR, 8'hC2);
    check("ready locking", {7'h00, mult_ready}, 8'h00);
    k = 0;
    while (mult_ready !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k = k + 1;
    end
    check("lock cycles", 8'(k), 8'(`MULT_LOCK_CYC));
    rd("control ready", `MULT_CTRL_ADDR, 8'hE2);
    // one slow external rise gives four pulses, then idle
    @(posedge sys_clk);
    ext_osc_level <= 1'b1;
    count_pulses(14);
    check("burst pulses", 8'(highs), 8'h04);
    ext_osc_level <= 1'b0;
    // source select picks the multiplier only for code 10
    @(posedge sys_clk);
    system_clock_source_select <= `SYSTEM_CLOCK_SRC_MULT;
    @(posedge sys_clk);
    #1;
    check("system_clock mult", {7'h00, system_clock_from_mult}, 8'h01);
    system_clock_source_select <= 2'h1;
    @(posedge sys_clk);
    #1;
    check("system_clock other", {7'h00, system_clock_from_mult}, 8'h00);
    // halved inputs: two rises of either oscillator give a single burst
    for (k = 0; k < 2; k++) begin
      wr(`MULT_CTRL_ADDR, 8'h00);
      wr(`MULT_CTRL_ADDR, 8'(k));
      wr(`MULT_CTRL_ADDR, 8'h80 | 8'(k));
      repeat (50) @(posedge sys_clk);
      wr(`MULT_CTRL_ADDR, 8'hC0 | 8'(k));
      repeat (`MULT_LOCK_CYC) @(posedge sys_clk);
      #1;
      check("ready halved", {7'h00, mult_ready}, 8'h01);
      pulses = 0;
      repeat (2) begin
        @(posedge sys_clk);
        {int_osc_level, ext_osc_level} <= 2'h3;
        count_pulses(12);
        pulses = pulses + highs;
        {int_osc_level, ext_osc_level} <= 2'h0;
      end
      check("halved pulses", 8'(pulses), 8'h04);
    end
    // disabling drops ready and stops bursts
    wr(`MULT_CTRL_ADDR, 8'h02);
    @(posedge sys_clk);
    #1;
    check("ready off", {7'h00, mult_ready}, 8'h00);
    ext_osc_level <= 1'b1;
    count_pulses(14);
    check("no burst", 8'(highs), 8'h00);
    complete_run();
  end
endmodule // osc_multiplier_control_test

`default_nettype wire
